/* File: inc/nalu_defines.vh */
// nalu_defines.vh: constants of the nibble alu with decimal adjust
// assumes inclusion by bare name from every design file of the block
`ifndef NALU_DEFINES_VH
`define NALU_DEFINES_VH

// ****************************************
// instruction codes
// ****************************************
`define NALU_OP_SUM                5'h00
`define NALU_OP_SUM_WITH_CARRY     5'h01
`define NALU_OP_DIFF               5'h02
`define NALU_OP_DIFF_WITH_BORROW   5'h03
`define NALU_OP_OR                 5'h04
`define NALU_OP_AND                5'h05
`define NALU_OP_XOR                5'h06
`define NALU_OP_SKIP_IF_BITS_TRUE  5'h07
`define NALU_OP_SKIP_IF_BITS_FALSE 5'h08
`define NALU_OP_SKIP_IF_EQUAL      5'h09
`define NALU_OP_SKIP_IF_UNEQUAL    5'h0A
`define NALU_OP_SKIP_IF_NOT_LESS   5'h0B
`define NALU_OP_SKIP_IF_LESS       5'h0C
`define NALU_OP_LOAD_REG_FROM_MEM  5'h0D
`define NALU_OP_WRITE_MEM_FROM_REG 5'h0E
`define NALU_OP_ROTATE_RIGHT_CARRY 5'h0F
`define NALU_OP_MOVE_OP_TO_IND     5'h10
`define NALU_OP_MOVE_OP_FROM_IND   5'h11

// ****************************************
// apb register offsets
// ****************************************
`define NALU_OFS_STATUS  8'h00
`define NALU_OFS_GRPTR   8'h04
`define NALU_OFS_BANK    8'h08
`define NALU_OFS_INDEX   8'h0C
`define NALU_OFS_ROWPTR  8'h10
`define NALU_OFS_STATE   8'h14

// ****************************************
// field positions and reset values
// ****************************************
`define NALU_ST_BCD      4
`define NALU_ST_COMPARE  3
`define NALU_ST_CARRY    2
`define NALU_ST_ZERO     1
`define NALU_ST_INDEX    0
`define NALU_RP_ENABLE   7
`define NALU_RST_FLAGS   5'h00
`define NALU_RST_GRPTR   7'h00
`define NALU_RST_BANK    4'h0
`define NALU_RST_INDEX   11'h000
`define NALU_RST_ROWPTR  7'h00

// row and column of the status word nibble in every bank
`define NALU_STATUS_LOC  7'h7F

// ****************************************
// decimal adjustment
// ****************************************
`define NALU_DEC_TEN     5'h0A
`define NALU_DEC_TWENTY  5'h14
`define NALU_DEC_DIGIT   4'hA
`define NALU_DEC_SIX     4'h6
`define NALU_DEC_BAD     2'h3

`endif

/* File: logic/nalu_dec_adj.v */
// nalu_dec_adj.v: decimal adjustment of a raw nibble sum or difference
// assumes raw_in carries the carry or borrow in bit 4, purely combinational
`timescale 1ns/10ps
`include "nalu_defines.vh"

module nalu_dec_adj
(
	input  wire [4:0] raw_in,
	input  wire       sub_in,
	input  wire       bcd_in,
	output reg  [3:0] res_out,
	output reg        carry_out
);

	wire [4:0] less_ten;

	assign less_ten = raw_in - `NALU_DEC_TEN;

	// ****************************************
	// binary pass or decimal correction
	// ****************************************
	always @*
	begin
		res_out = raw_in[3:0];
		carry_out = raw_in[4];
		if (bcd_in)
		begin
			if (!sub_in)
			begin
				if (raw_in < `NALU_DEC_TEN)
					carry_out = 1'b0;
				else if (raw_in < `NALU_DEC_TWENTY)
				begin
					carry_out = 1'b1;
					res_out = less_ten[3:0];
				end
				else
				begin
					carry_out = 1'b1;
					res_out = {`NALU_DEC_BAD, raw_in[1:0]};
				end
			end
			else if (!raw_in[4])
			begin
				if (raw_in[3:0] < `NALU_DEC_DIGIT)
					carry_out = 1'b0;
				else
				begin
					carry_out = 1'b1;
					res_out = {`NALU_DEC_BAD, raw_in[1:0]};
				end
			end
			else if (raw_in[3:0] >= `NALU_DEC_SIX)
			begin
				carry_out = 1'b1;
				res_out = raw_in[3:0] - `NALU_DEC_SIX;
			end
			else
			begin
				carry_out = 1'b1;
				res_out = {`NALU_DEC_BAD, raw_in[1:0]};
			end
		end
	end

endmodule // nalu_dec_adj

/* File: logic/nalu_core.v */
// nalu_core.v: nibble alu datapath with flags, address forming and apb
// assumes a data memory on mclk_in answering a read one cycle after rd
`timescale 1ns/10ps
`include "nalu_defines.vh"

// Behaviour
// - arithmetic, logic, test, rotate, transfer on nibbles
// - two hidden holding registers latch operands
// - decimal flag set selects decimal adjusted result
// - compare clear: zero flag equals result zero
// - compare set: nonzero result clears, zero keeps
// - logic, skip, transfer keep carry and zero
// - rotate right through carry, bit 0 to carry
// - register operand: pointer bank/row, instruction column
// - index enabled: direct address ORed with index
// - index enabled: indirect bank/row ORed with index
// - row pointer enabled: indirect bank/row from pointer, not indexed
// - decimal add: 10 to 19 carry, minus ten
// - decimal subtract: -10 to -1 borrow, plus ten
// - status word destination: result overwrites all flags but decimal
module nalu_core
(
	input  wire        mclk_in,
	input  wire        resetn_in,
	input  wire        psel_in,
	input  wire        penable_in,
	input  wire        pwrite_in,
	input  wire [7:0]  paddr_in,
	input  wire [31:0] pwdata_in,
	output reg  [31:0] prdata_out,
	output reg         pready_out,
	output reg         pslverr_out,
	input  wire        instr_valid_in,
	input  wire [4:0]  instr_op_in,
	input  wire        instr_imm_in,
	input  wire [3:0]  instr_gcol_in,
	input  wire [2:0]  instr_mrow_in,
	input  wire [3:0]  instr_mcol_in,
	input  wire [3:0]  instr_n4_in,
	output reg         busy_out,
	output reg         done_out,
	output reg         skip_out,
	output reg  [10:0] mem_addr_out,
	output reg         mem_rd_out,
	output reg         mem_wr_out,
	output reg  [3:0]  mem_wdata_out,
	input  wire [3:0]  mem_rdata_in
);

	localparam S_IDLE = 3'd0;
	localparam S_RD1  = 3'd1;
	localparam S_CAP1 = 3'd2;
	localparam S_RD2  = 3'd3;
	localparam S_CAP2 = 3'd4;
	localparam S_EXEC = 3'd5;

	reg  [2:0]  state;
	reg  [4:0]  op_q;
	reg         imm_q;
	reg  [3:0]  gcol_q;
	reg  [2:0]  mrow_q;
	reg  [3:0]  mcol_q;
	reg  [3:0]  tmp_a;
	reg  [3:0]  tmp_b;
	reg         bcd_flag;
	reg         compare_flag;
	reg         carry_flag;
	reg         zero_flag;
	reg         index_enable_flag;
	reg  [6:0]  gen_reg_pointer;
	reg  [3:0]  bank_sel;
	reg  [10:0] index_modifier;
	reg  [6:0]  row_pointer;
	reg         row_pointer_enable;
	reg         last_skip;
	reg  [4:0]  raw_res;
	reg         ex_wr;
	reg  [10:0] ex_addr;
	reg  [3:0]  ex_data;
	reg         ex_skip;
	reg  [31:0] next_rdata;
	reg         reg_hit;
	wire [3:0]  adj_res;
	wire        adj_carry;
	wire        sub_op;
	wire        carry_in;
	wire        apb_wr;

	// ****************************************
	// address forming and decode helpers
	// ****************************************
	function [10:0] gr_addr;
		input [3:0] col;
		gr_addr = {gen_reg_pointer, col};
	endfunction

	function [10:0] dm_addr;
		input [2:0] row;
		input [3:0] col;
		begin
			dm_addr = {bank_sel, row, col};
			if (index_enable_flag)
				dm_addr = dm_addr | index_modifier;
		end
	endfunction

	function [10:0] ind_addr;
		input [2:0] row;
		input [3:0] col;
		begin
			if (row_pointer_enable)
				ind_addr = {row_pointer, col};
			else
			begin
				ind_addr = {bank_sel, row, col};
				if (index_enable_flag)
					ind_addr = ind_addr | {index_modifier[10:4], 4'h0};
			end
		end
	endfunction

	function is_arith;
		input [4:0] op;
		is_arith = (op <= `NALU_OP_DIFF_WITH_BORROW);
	endfunction

	function is_logic;
		input [4:0] op;
		is_logic = (op >= `NALU_OP_OR) && (op <= `NALU_OP_XOR);
	endfunction

	function reads_reg_first;
		input [4:0] op;
		input       imm;
		begin
			if (is_arith(op) || is_logic(op))
				reads_reg_first = !imm;
			else
				reads_reg_first = (op >= `NALU_OP_WRITE_MEM_FROM_REG) &&
					(op <= `NALU_OP_MOVE_OP_FROM_IND);
		end
	endfunction

	function needs_second;
		input [4:0] op;
		input       imm;
		needs_second = ((is_arith(op) || is_logic(op)) && !imm) ||
			(op == `NALU_OP_MOVE_OP_TO_IND) ||
			(op == `NALU_OP_MOVE_OP_FROM_IND);
	endfunction

	// ****************************************
	// arithmetic core and decimal adjust
	// ****************************************
	assign sub_op = (op_q == `NALU_OP_DIFF) ||
		(op_q == `NALU_OP_DIFF_WITH_BORROW);
	assign carry_in = carry_flag && ((op_q == `NALU_OP_SUM_WITH_CARRY) ||
		(op_q == `NALU_OP_DIFF_WITH_BORROW));

	// five bit raw result, bit 4 is carry or borrow
	always @*
	begin
		if (sub_op)
			raw_res = {1'b0, tmp_a} - {1'b0, tmp_b} - {4'h0, carry_in};
		else
			raw_res = {1'b0, tmp_a} + {1'b0, tmp_b} + {4'h0, carry_in};
	end

	nalu_dec_adj u_dec_adj
	(
		.raw_in    (raw_res),
		.sub_in    (sub_op),
		.bcd_in    (bcd_flag),
		.res_out   (adj_res),
		.carry_out (adj_carry)
	);

	// ****************************************
	// execute: destination, data, skip
	// ****************************************
	// helpers read pointers and index, so they are listed by hand
	always @(op_q or imm_q or gcol_q or mrow_q or mcol_q or tmp_a or tmp_b or
		compare_flag or carry_flag or adj_res or gen_reg_pointer or bank_sel or
		index_enable_flag or index_modifier or row_pointer or
		row_pointer_enable)
	begin
		ex_wr = 1'b0;
		ex_addr = dm_addr(mrow_q, mcol_q);
		ex_data = tmp_b;
		ex_skip = 1'b0;
		case (op_q)
			`NALU_OP_SUM, `NALU_OP_SUM_WITH_CARRY,
			`NALU_OP_DIFF, `NALU_OP_DIFF_WITH_BORROW:
			begin
				ex_wr = !compare_flag;
				ex_data = adj_res;
				if (!imm_q)
					ex_addr = gr_addr(gcol_q);
			end
			`NALU_OP_OR, `NALU_OP_AND, `NALU_OP_XOR:
			begin
				ex_wr = 1'b1;
				if (op_q == `NALU_OP_OR)
					ex_data = tmp_a | tmp_b;
				else if (op_q == `NALU_OP_AND)
					ex_data = tmp_a & tmp_b;
				else
					ex_data = tmp_a ^ tmp_b;
				if (!imm_q)
					ex_addr = gr_addr(gcol_q);
			end
			`NALU_OP_SKIP_IF_BITS_TRUE:
				ex_skip = ((tmp_a & tmp_b) == tmp_b);
			`NALU_OP_SKIP_IF_BITS_FALSE:
				ex_skip = ((tmp_a & tmp_b) == 4'h0);
			`NALU_OP_SKIP_IF_EQUAL:
				ex_skip = (tmp_a == tmp_b);
			`NALU_OP_SKIP_IF_UNEQUAL:
				ex_skip = (tmp_a != tmp_b);
			`NALU_OP_SKIP_IF_NOT_LESS:
				ex_skip = (tmp_a >= tmp_b);
			`NALU_OP_SKIP_IF_LESS:
				ex_skip = (tmp_a < tmp_b);
			`NALU_OP_LOAD_REG_FROM_MEM:
			begin
				ex_wr = 1'b1;
				if (!imm_q)
				begin
					ex_addr = gr_addr(gcol_q);
					ex_data = tmp_a;
				end
			end
			`NALU_OP_WRITE_MEM_FROM_REG:
			begin
				ex_wr = 1'b1;
				ex_data = tmp_a;
			end
			`NALU_OP_ROTATE_RIGHT_CARRY:
			begin
				ex_wr = 1'b1;
				ex_addr = gr_addr(gcol_q);
				ex_data = {carry_flag, tmp_a[3:1]};
			end
			`NALU_OP_MOVE_OP_TO_IND:
			begin
				ex_wr = 1'b1;
				ex_addr = ind_addr(mrow_q, tmp_a);
			end
			`NALU_OP_MOVE_OP_FROM_IND:
				ex_wr = 1'b1;
			default:
				ex_wr = 1'b0;
		endcase
	end

	// ****************************************
	// sequencer: fetch operands, execute
	// ****************************************
	always @(posedge mclk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			state <= S_IDLE;
			op_q <= 5'h00;
			imm_q <= 1'b0;
			gcol_q <= 4'h0;
			mrow_q <= 3'h0;
			mcol_q <= 4'h0;
			tmp_a <= 4'h0;
			tmp_b <= 4'h0;
			busy_out <= 1'b0;
			done_out <= 1'b0;
			skip_out <= 1'b0;
			last_skip <= 1'b0;
			mem_addr_out <= 11'h000;
			mem_rd_out <= 1'b0;
			mem_wr_out <= 1'b0;
			mem_wdata_out <= 4'h0;
		end
		else
		begin
			done_out <= 1'b0;
			skip_out <= 1'b0;
			mem_rd_out <= 1'b0;
			mem_wr_out <= 1'b0;
			case (state)
				S_IDLE:
					if (instr_valid_in)
					begin
						op_q <= instr_op_in;
						imm_q <= instr_imm_in;
						gcol_q <= instr_gcol_in;
						mrow_q <= instr_mrow_in;
						mcol_q <= instr_mcol_in;
						tmp_b <= instr_n4_in;
						busy_out <= 1'b1;
						if (instr_op_in == `NALU_OP_LOAD_REG_FROM_MEM &&
							instr_imm_in)
							state <= S_EXEC;
						else
						begin
							state <= S_RD1;
							mem_rd_out <= 1'b1;
							if (reads_reg_first(instr_op_in, instr_imm_in))
								mem_addr_out <= gr_addr(instr_gcol_in);
							else
								mem_addr_out <= dm_addr(instr_mrow_in,
									instr_mcol_in);
						end
					end
				S_RD1:
					state <= S_CAP1;
				S_CAP1:
				begin
					tmp_a <= mem_rdata_in;
					if (needs_second(op_q, imm_q))
					begin
						state <= S_RD2;
						mem_rd_out <= 1'b1;
						if (op_q == `NALU_OP_MOVE_OP_FROM_IND)
							mem_addr_out <= ind_addr(mrow_q, mem_rdata_in);
						else
							mem_addr_out <= dm_addr(mrow_q, mcol_q);
					end
					else
						state <= S_EXEC;
				end
				S_RD2:
					state <= S_CAP2;
				S_CAP2:
				begin
					tmp_b <= mem_rdata_in;
					state <= S_EXEC;
				end
				S_EXEC:
				begin
					state <= S_IDLE;
					busy_out <= 1'b0;
					done_out <= 1'b1;
					skip_out <= ex_skip;
					last_skip <= ex_skip;
					mem_wr_out <= ex_wr;
					mem_addr_out <= ex_addr;
					mem_wdata_out <= ex_data;
				end
				default:
					state <= S_IDLE;
			endcase
		end
	end

	// ****************************************
	// apb slave: decode and read mux
	// ****************************************
	assign apb_wr = psel_in && penable_in && pready_out && pwrite_in &&
		reg_hit;

	always @*
	begin
		reg_hit = 1'b1;
		next_rdata = 32'h00000000;
		case (paddr_in)
			`NALU_OFS_STATUS:
				next_rdata = {27'h0000000, bcd_flag, compare_flag,
					carry_flag, zero_flag, index_enable_flag};
			`NALU_OFS_GRPTR:
				next_rdata = {25'h0000000, gen_reg_pointer};
			`NALU_OFS_BANK:
				next_rdata = {28'h0000000, bank_sel};
			`NALU_OFS_INDEX:
				next_rdata = {21'h000000, index_modifier};
			`NALU_OFS_ROWPTR:
				next_rdata = {24'h000000, row_pointer_enable, row_pointer};
			`NALU_OFS_STATE:
				next_rdata = {27'h0000000, last_skip, busy_out, state};
			default:
				reg_hit = 1'b0;
		endcase
	end

	// no wait state: answer registered in the setup cycle
	always @(posedge mclk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h00000000;
		end
		else
		begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			if (psel_in && !penable_in && !pready_out)
			begin
				pready_out <= 1'b1;
				pslverr_out <= !reg_hit;
				prdata_out <= pwrite_in ? 32'h00000000 : next_rdata;
			end
		end
	end

	// ****************************************
	// flags and pointers: bus writes, alu updates
	// ****************************************
	always @(posedge mclk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			{bcd_flag, compare_flag, carry_flag, zero_flag,
				index_enable_flag} <= `NALU_RST_FLAGS;
			gen_reg_pointer <= `NALU_RST_GRPTR;
			bank_sel <= `NALU_RST_BANK;
			index_modifier <= `NALU_RST_INDEX;
			row_pointer <= `NALU_RST_ROWPTR;
			row_pointer_enable <= 1'b0;
		end
		else
		begin
			if (apb_wr && paddr_in == `NALU_OFS_STATUS)
			begin
				bcd_flag <= pwdata_in[`NALU_ST_BCD];
				compare_flag <= pwdata_in[`NALU_ST_COMPARE];
				carry_flag <= pwdata_in[`NALU_ST_CARRY];
				zero_flag <= pwdata_in[`NALU_ST_ZERO];
				index_enable_flag <= pwdata_in[`NALU_ST_INDEX];
			end
			if (apb_wr && paddr_in == `NALU_OFS_GRPTR)
				gen_reg_pointer <= pwdata_in[6:0];
			if (apb_wr && paddr_in == `NALU_OFS_BANK)
				bank_sel <= pwdata_in[3:0];
			if (apb_wr && paddr_in == `NALU_OFS_INDEX)
				index_modifier <= pwdata_in[10:0];
			if (apb_wr && paddr_in == `NALU_OFS_ROWPTR)
			begin
				row_pointer <= pwdata_in[6:0];
				row_pointer_enable <= pwdata_in[`NALU_RP_ENABLE];
			end
			// alu updates come last so they win over a bus write
			if (state == S_EXEC)
			begin
				if (is_arith(op_q))
				begin
					carry_flag <= adj_carry;
					if (!compare_flag)
						zero_flag <= (adj_res == 4'h0);
					else if (adj_res != 4'h0)
						zero_flag <= 1'b0;
				end
				if (op_q == `NALU_OP_ROTATE_RIGHT_CARRY)
					carry_flag <= tmp_a[0];
				if (op_q == `NALU_OP_SKIP_IF_BITS_TRUE ||
					op_q == `NALU_OP_SKIP_IF_BITS_FALSE)
					compare_flag <= 1'b0;
				// other ops leave carry and zero alone
				if (ex_wr && ex_addr[6:0] == `NALU_STATUS_LOC)
					{compare_flag, carry_flag, zero_flag,
						index_enable_flag} <= ex_data;
			end
		end
	end

endmodule // nalu_core

/* File: verification/nalu_mem_model.sv */
// nalu_mem_model.sv: data memory on the far side of the alu core
// assumes one clock; read data stands two cycles after the strobe
`timescale 1ns/10ps

module nalu_mem_model
(
	input  wire        clk_in,
	input  wire [10:0] addr_in,
	input  wire        rd_in,
	input  wire        wr_in,
	input  wire [3:0]  wdata_in,
	output reg  [3:0]  rdata_out
);
	logic [3:0] mem [0:2047];
	int         hold = 0;

	initial rdata_out = 4'h5;

	// write on strobe; read held two cycles, then scrambled
	always @(posedge clk_in)
	begin
		if (wr_in)
			mem[addr_in] <= wdata_in;
		if (rd_in)
		begin
			rdata_out <= mem[addr_in];
			hold <= 2;
		end
		else if (hold > 1)
			hold <= hold - 1;
		else
			rdata_out <= ~rdata_out; // stale data never lingers
	end
endmodule // nalu_mem_model

/* File: verification/nalu_core_asserts.sv */
// nalu_core_asserts.sv: port checks of the nibble alu core
// assumes binding to nalu_core, one clock, async low reset
`timescale 1ns/10ps
`include "nalu_defines.vh"

module nalu_core_asserts
(
	input wire        mclk_in,
	input wire        resetn_in,
	input wire        psel_in,
	input wire        penable_in,
	input wire [31:0] prdata_out,
	input wire        pready_out,
	input wire        pslverr_out,
	input wire        instr_valid_in,
	input wire [4:0]  instr_op_in,
	input wire        instr_imm_in,
	input wire [3:0]  instr_n4_in,
	input wire        busy_out,
	input wire        done_out,
	input wire        skip_out,
	input wire        mem_rd_out,
	input wire        mem_wr_out,
	input wire [3:0]  mem_wdata_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);
	logic [4:0] op_q;

	// ****************************************
	// helpers
	// ****************************************
	sequence s_accept;
		instr_valid_in && !busy_out;
	endsequence
	sequence s_setup;
		psel_in && !penable_in;
	endsequence
	// opcode of the running instruction
	always @(posedge mclk_in or negedge resetn_in)
		if (!resetn_in)
			op_q <= 5'h00;
		else if (instr_valid_in && !busy_out)
			op_q <= instr_op_in;

	// ****************************************
	// assertions
	// ****************************************
	chk_apb_answer: assert property (s_setup |=> pready_out && penable_in)
		else $error("apb access phase not answered");
	chk_err_data: assert property (pslverr_out |-> pready_out
		&& prdata_out == 32'h0) else $error("bad error response");
	chk_ready_pulse: assert property (pready_out |=> !pready_out)
		else $error("pready longer than one cycle");
	chk_instr_done: assert property (s_accept |=> busy_out ##[1:6]
		(done_out && !busy_out)) else $error("instruction not finished");
	chk_imm_move: assert property (s_accept
		and instr_op_in == `NALU_OP_LOAD_REG_FROM_MEM && instr_imm_in
		|-> ##2 done_out && mem_wr_out
		&& mem_wdata_out == $past(instr_n4_in, 2))
		else $error("immediate move wrong");
	chk_skip_done: assert property (skip_out |-> done_out)
		else $error("skip outside done");
	chk_skip_ops: assert property (skip_out |-> op_q >= 5'h07
		&& op_q <= 5'h0C) else $error("skip from non-skip op");
	chk_skip_nowr: assert property (done_out && op_q >= 5'h07
		&& op_q <= 5'h0C |-> !mem_wr_out) else $error("skip op wrote");
	chk_wr_done: assert property (mem_wr_out |-> done_out)
		else $error("write outside done");
	chk_done_quiet: assert property (done_out |-> !mem_rd_out)
		else $error("read during done");
endmodule // nalu_core_asserts

bind nalu_core nalu_core_asserts nalu_core_asserts_i (.mclk_in, .resetn_in,
	.psel_in, .penable_in, .prdata_out, .pready_out, .pslverr_out,
	.instr_valid_in, .instr_op_in, .instr_imm_in, .instr_n4_in, .busy_out,
	.done_out, .skip_out, .mem_rd_out, .mem_wr_out, .mem_wdata_out);

/* File: verification/nibble_alu_with_decimal_adjust_test.sv */
// nibble_alu_with_decimal_adjust_test.sv: self-checking bench of nalu_core
// assumes nalu_mem_model as data memory and the bound checker
`timescale 1ns/10ps
`include "nalu_defines.vh"

module nibble_alu_with_decimal_adjust_test;
	logic        mclk_in = 1'b0, resetn_in = 1'b0;
	logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
	logic [7:0]  paddr_in = 8'h00;
	logic [31:0] pwdata_in = 32'h0, prdata_out, q;
	logic        pready_out, pslverr_out, busy_out, done_out, skip_out, e;
	logic        instr_valid_in = 1'b0, instr_imm_in = 1'b0;
	logic [4:0]  instr_op_in = 5'h00;
	logic [3:0]  instr_gcol_in = 4'h6, instr_mcol_in = 4'h0;
	logic [3:0]  instr_n4_in = 4'h0, mem_wdata_out, mem_rdata_in;
	logic [2:0]  instr_mrow_in = 3'h0;
	logic [10:0] mem_addr_out;
	logic        mem_rd_out, mem_wr_out;
	logic [6:0]  mloc = 7'h12; // direct operand row and column
	int          miscompares = 0, checks = 0, cycles = 0;
	localparam logic [6:0] GRP = 7'h2D;
	localparam logic [3:0] BNK = 4'h3;

	always #5 mclk_in = ~mclk_in;

	nalu_core nalu_core_i (.mclk_in, .resetn_in, .psel_in, .penable_in,
		.pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
		.pslverr_out, .instr_valid_in, .instr_op_in, .instr_imm_in,
		.instr_gcol_in, .instr_mrow_in, .instr_mcol_in, .instr_n4_in,
		.busy_out, .done_out, .skip_out, .mem_addr_out, .mem_rd_out,
		.mem_wr_out, .mem_wdata_out, .mem_rdata_in);
	nalu_mem_model nalu_mem_model_i (.clk_in(mclk_in), .addr_in(mem_addr_out),
		.rd_in(mem_rd_out), .wr_in(mem_wr_out), .wdata_in(mem_wdata_out),
		.rdata_out(mem_rdata_in));

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer, answer taken at the pready edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge mclk_in);
		penable_in <= 1'b1;
		do
			@(posedge mclk_in);
		while (pready_out !== 1'b1);
		q = prdata_out;
		e = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge mclk_in);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(q, exp);
	endtask
	// one instruction, returns one edge after the edge closing done
	task automatic run(input logic [4:0] op, input logic imm,
		input logic [3:0] n);
		int k, want;
		// edges from accept to done: immediate move, one read, two reads
		want = (op == `NALU_OP_LOAD_REG_FROM_MEM && imm) ? 2 :
			((op <= `NALU_OP_XOR && !imm) ||
			op >= `NALU_OP_MOVE_OP_TO_IND) ? 6 : 4;
		instr_valid_in <= 1'b1;
		instr_op_in <= op;
		instr_imm_in <= imm;
		{instr_mrow_in, instr_mcol_in} <= mloc;
		instr_n4_in <= n;
		@(posedge mclk_in);
		instr_valid_in <= 1'b0;
		k = 0;
		do
		begin
			@(posedge mclk_in);
			k++;
		end
		while (done_out !== 1'b1);
		check(k, want);
		e = skip_out;
		// the memory write lands at the done edge; let it settle
		@(posedge mclk_in);
	endtask
	// v: r, m, n4, exp r, exp m, exp skip; f: status in, status out
	task automatic case_run(input logic [4:0] op, input logic imm,
		input logic [23:0] v, input logic [15:0] f);
		logic [10:0] ra, ma;
		ra = {GRP, instr_gcol_in};
		ma = {BNK, mloc};
		apb(1'b1, `NALU_OFS_STATUS, {24'h0, f[15:8]});
		nalu_mem_model_i.mem[ra] = v[23:20];
		nalu_mem_model_i.mem[ma] = v[19:16];
		run(op, imm, v[15:12]);
		check(e, v[3:0]);
		check(nalu_mem_model_i.mem[ra], v[11:8]);
		check(nalu_mem_model_i.mem[ma], v[7:4]);
		rd(`NALU_OFS_STATUS, {24'h0, f[7:0]});
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		rd(`NALU_OFS_STATUS, 32'h0);
		rd(`NALU_OFS_INDEX, 32'h0);
		rd(8'h40, 32'h0);
		check(e, 1'b1);
		apb(1'b1, `NALU_OFS_GRPTR, {25'h0, GRP});
		apb(1'b1, `NALU_OFS_BANK, {28'h0, BNK});
		rd(`NALU_OFS_GRPTR, {25'h0, GRP});
		$display("test reset done");
	endtask
	task automatic t_arith;
		case_run(`NALU_OP_SUM, 1'b0, 24'h980180, 16'h0004);
		case_run(`NALU_OP_SUM, 1'b0, 24'h120320, 16'h0200);
		case_run(`NALU_OP_DIFF, 1'b0, 24'h790790, 16'h0A0C);
		case_run(`NALU_OP_DIFF, 1'b0, 24'h550550, 16'h0A0A);
		case_run(`NALU_OP_SUM_WITH_CARRY, 1'b0, 24'h780080, 16'h0406);
		case_run(`NALU_OP_DIFF_WITH_BORROW, 1'b0, 24'h540040, 16'h0402);
		$display("test arith done");
	endtask
	task automatic t_decimal;
		logic [3:0]  a, b, res;
		logic [23:0] v;
		logic [15:0] f;
		for (int s = -10; s < 20; s++)
		begin
			a = (s < 0) ? 4'h0 : 4'(s / 2);
			b = (s < 0) ? 4'(-s) : 4'(s - s / 2);
			res = (s < 0) ? 4'(s + 10) : (s > 9) ? 4'(s - 10) : 4'(s);
			v = {4'h0, a, b, 4'h0, res, 4'h0};
			f = {8'h10, 4'h1, 1'b0, s < 0 || s > 9, res == 4'h0, 1'b0};
			case_run((s < 0) ? `NALU_OP_DIFF : `NALU_OP_SUM, 1'b1, v, f);
		end
		$display("test decimal done");
	endtask
	task automatic t_logic;
		case_run(`NALU_OP_OR, 1'b1, 24'h0CA0E0, 16'h0606);
		case_run(`NALU_OP_AND, 1'b1, 24'h0CA080, 16'h0606);
		case_run(`NALU_OP_XOR, 1'b1, 24'h0CA060, 16'h0606);
		case_run(`NALU_OP_OR, 1'b0, 24'h3C0FC0, 16'h0606);
		case_run(`NALU_OP_LOAD_REG_FROM_MEM, 1'b1, 24'h0CA0A0, 16'h0606);
		case_run(`NALU_OP_LOAD_REG_FROM_MEM, 1'b0, 24'h3C0CC0, 16'h0606);
		case_run(`NALU_OP_WRITE_MEM_FROM_REG, 1'b0, 24'h3C0330, 16'h0606);
		$display("test logic done");
	endtask
	task automatic t_skip;
		case_run(`NALU_OP_SKIP_IF_BITS_TRUE, 1'b1, 24'h0C80C1, 16'h0E06);
		case_run(`NALU_OP_SKIP_IF_BITS_TRUE, 1'b1, 24'h0C30C0, 16'h0606);
		case_run(`NALU_OP_SKIP_IF_BITS_FALSE, 1'b1, 24'h0C30C1, 16'h0606);
		case_run(`NALU_OP_SKIP_IF_BITS_FALSE, 1'b1, 24'h0C80C0, 16'h0606);
		case_run(`NALU_OP_SKIP_IF_EQUAL, 1'b1, 24'h055051, 16'h0E0E);
		case_run(`NALU_OP_SKIP_IF_UNEQUAL, 1'b1, 24'h055050, 16'h0606);
		case_run(`NALU_OP_SKIP_IF_NOT_LESS, 1'b1, 24'h056050, 16'h0606);
		case_run(`NALU_OP_SKIP_IF_LESS, 1'b1, 24'h056051, 16'h0606);
		$display("test skip done");
	endtask
	task automatic t_rotate;
		case_run(`NALU_OP_ROTATE_RIGHT_CARRY, 1'b0, 24'h500200, 16'h0206);
		case_run(`NALU_OP_ROTATE_RIGHT_CARRY, 1'b0, 24'h200900, 16'h0400);
		$display("test rotate done");
	endtask
	task automatic t_status;
		mloc = 7'h7F;
		case_run(`NALU_OP_SUM, 1'b1, 24'h03E030, 16'h080C);
		case_run(`NALU_OP_SUM, 1'b1, 24'h03E010, 16'h0001);
		apb(1'b1, `NALU_OFS_STATUS, 32'h0);
		mloc = 7'h12;
		$display("test status done");
	endtask
	task automatic t_index;
		logic [10:0] src, dst;
		src = {BNK, mloc} | 11'h135;
		dst = {BNK, mloc[6:4], 4'h9} | 11'h130;
		apb(1'b1, `NALU_OFS_INDEX, 32'h135);
		apb(1'b1, `NALU_OFS_STATUS, 32'h1);
		nalu_mem_model_i.mem[{GRP, instr_gcol_in}] = 4'h9;
		nalu_mem_model_i.mem[src] = 4'hB;
		run(`NALU_OP_MOVE_OP_TO_IND, 1'b0, 4'h0);
		check(nalu_mem_model_i.mem[dst], 4'hB);
		// row pointer takes over; direct operand stays unindexed
		apb(1'b1, `NALU_OFS_STATUS, 32'h0);
		apb(1'b1, `NALU_OFS_ROWPTR, 32'hD5);
		nalu_mem_model_i.mem[{BNK, mloc}] = 4'h4;
		run(`NALU_OP_MOVE_OP_TO_IND, 1'b0, 4'h0);
		check(nalu_mem_model_i.mem[{7'h55, 4'h9}], 4'h4);
		// indirect source through the row pointer lands in m
		nalu_mem_model_i.mem[{7'h55, 4'h9}] = 4'h7;
		run(`NALU_OP_MOVE_OP_FROM_IND, 1'b0, 4'h0);
		check(nalu_mem_model_i.mem[{BNK, mloc}], 4'h7);
		apb(1'b1, `NALU_OFS_ROWPTR, 32'h0);
		$display("test index done");
	endtask

	// ****************************************
	// sequence and verdict
	// ****************************************
	task automatic stop_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge mclk_in);
		resetn_in <= 1'b1;
		@(posedge mclk_in);
		t_reset;
		t_arith;
		t_decimal;
		t_logic;
		t_skip;
		t_rotate;
		t_status;
		t_index;
		stop_test;
	end
	// hang guard
	always @(posedge mclk_in)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			miscompares++;
			stop_test;
		end
	end
endmodule // nibble_alu_with_decimal_adjust_test
